// [rtl/pte_pkg.sv]
/*
  Constants, register map and carrier types of the trigger and error inserter.
  Assumes one output bit per mclk cycle and an AXI4-Lite master for software.
*/
// Functional notes
// RQ1: Pattern-mode trigger pulse lasts at least 32 bit periods per pattern start.
// RQ2: Sequence-mode spike on block start or restart, only for flagged blocks.
// RQ3: Even divider n gives n/2 periods high then n/2 low.
// RQ4: Odd divider n gives (n+1)/2 periods high, (n-1)/2 low.
// RQ5: Divided clock always selectable; pattern triggers suppressed in sequence mode.
// RQ6: Programmable trigger delay; zero keeps trigger aligned with data.
// RQ7: Sequence trigger unavailable until a user sequence is loaded.
// RQ8: Errors invert single data bits; pattern content otherwise untouched.
// RQ9: Continuous insertion flips bits at selected ratio in selected mode.
// RQ10: Single-error execute inverts exactly one outgoing bit.
// RQ11: Encoded-error and plain bit-error insertion act independently and together.
// RQ12: Encoding active only when an encoded factory pattern is chosen.
// RQ13: Controller gives encoded blocks length 5440, loops infinite or multiple of 8.
// RQ14: Switching encoded and plain blocks may briefly output invalid encoded data.
// RQ15: Continuous encoded errors are injected after the encoder.
// RQ16: Per frame, configured symbols corrupted at random, one random bit each.
// RQ17: Single parity error inserted before encoder, accepted at any time.
// RQ18: Each channel encodes independently; same sequence gives identical bits.
// RQ19: Random positions come from an internal generator advanced every frame; fecRng here steps every cycle.
`default_nettype none
package pte_pkg;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_TRIG   = 8'h04;
  localparam logic [7:0]  ADDR_ERR    = 8'h08;
  localparam logic [7:0]  ADDR_CMD    = 8'h0C;
  localparam logic [7:0]  ADDR_STAT   = 8'h10;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [31:0] MASK_CTRL   = 32'h0000_003F;
  localparam logic [31:0] MASK_TRIG   = 32'h0000_0FFF;
  localparam logic [31:0] MASK_ERR    = 32'h0000_03FF;
  localparam logic [31:0] RST_TRIG    = 32'h0000_0008;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ERREN     = 2;
  localparam int CTRL_ERRMODE   = 3;
  localparam int CTRL_SINGLEEN  = 4;
  localparam int CTRL_FECERREN  = 5;
  localparam int TRIG_DIV_LSB   = 0;
  localparam int TRIG_DLY_LSB   = 8;
  localparam int ERR_RATIO_LSB  = 0;
  localparam int ERR_NSYM_LSB   = 4;
  localparam int CMD_SINGLE     = 0;
  localparam int CMD_PARITY     = 1;
  localparam logic [5:0]  PAT_PULSE_LEN = 6'h20;
  localparam logic [3:0]  SYM_BITS      = 4'hA;
  localparam logic [9:0]  FRAME_SYMS    = 10'h220;
  localparam logic [3:0]  POS_WRAP      = 4'h6;
  localparam logic [15:0] SEED_BIT      = 16'hACE1;
  localparam logic [15:0] SEED_FEC      = 16'h1D0F;
  localparam logic [15:0] LFSR_TAPS     = 16'hB400;
  localparam logic [15:0] ONE16         = 16'h0001;

  typedef enum logic [1:0] {
    TRIG_DIV = 2'b00,
    TRIG_PAT = 2'b01,
    TRIG_SEQ = 2'b10
  } pte_trig_e;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] trig;
    logic [31:0] err;
  } pte_regs_s;
endpackage
`default_nettype wire

// [rtl/pte_lfsr.sv]
/*
  Galois pseudo-random generator that steps every cycle.
  Assumes a synchronous reset that reloads the fixed seed.
*/
`timescale 1ns/100ps
`default_nettype none
module pte_lfsr #(
  parameter logic [15:0] SEED = 16'h0001
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // State
  output var  logic [15:0] state
);
  logic [15:0] next_state;

  always_comb begin
    next_state = (state >> 1) ^ (state[0] ? pte_pkg::LFSR_TAPS : 16'h0000);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= SEED;
    end else begin
      state <= next_state;
    end
  end
endmodule // pte_lfsr
`default_nettype wire

// [rtl/pte_top.sv]
/*
  Trigger generator and error inserter of one output channel, AXI4-Lite slave.
  Assumes pattern, sequencer and external encoder strobes are synchronous to mclk.
*/
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pte_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // AXI4-Lite write
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  // Pattern and sequencer
  input  wire logic        dataIn,
  input  wire logic        patternStart,
  input  wire logic        seqMode,
  input  wire logic        seqLoaded,
  input  wire logic        blockStart,
  input  wire logic        blockTrigFlag,
  input  wire logic        fecPattern,
  // External encoder
  output var  logic        encoderEnable,
  output var  logic        preEncOut,
  input  wire logic        encIn,
  input  wire logic        frameStart,
  // Outputs
  output var  logic        dataOut,
  output var  logic        trigOut
);
  pte_pkg::pte_regs_s regs, next_regs;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, strbMask, statusWord;
  logic        wrFire, cmdSingle, cmdParity, modeWriteOk;
  pte_pkg::pte_trig_e trigMode;
  logic [7:0]  divider, divCnt, next_divCnt;
  logic [8:0]  halfHi;
  logic [3:0]  trigDelay;
  logic [5:0]  patCnt, next_patCnt;
  logic [14:0] trigPipe, next_trigPipe;
  logic        next_trigOut, divHigh, patHigh, patTerm, seqSpike, rawTrig;
  logic [15:0] lfsrBit, lfsrFec, ratioMask, periodCnt, next_periodCnt;
  logic        ratioHit, bitFlip, baseBit, singlePend, next_singlePend;
  logic        parityPend, next_parityPend, next_dataOut, next_preEncOut;
  logic [3:0]  bitCnt, next_bitCnt, curIdx, armPos, next_armPos, randPos;
  logic [9:0]  symLeft, next_symLeft, curLeft;
  logic [5:0]  remaining, next_remaining, curRem;
  logic        armed, next_armed, symHit, symFlip;

  assign trigMode  = pte_pkg::pte_trig_e'(regs.ctrl[pte_pkg::CTRL_MODE_LSB +: 2]);
  assign divider   = regs.trig[pte_pkg::TRIG_DIV_LSB +: 8];
  assign trigDelay = regs.trig[pte_pkg::TRIG_DLY_LSB +: 4];
  assign strbMask  = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign statusWord = {26'h000_0000, parityPend, singlePend, encoderEnable, seqLoaded, seqMode, trigOut};

  // Register bus: address and data are taken together, one cycle after both are offered.
  always_comb begin
    next_awready = 1'b0;
    next_wready  = 1'b0;
    next_bvalid  = bvalid & ~bready;
    next_bresp   = bresp;
    next_arready = 1'b0;
    next_rvalid  = rvalid & ~rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_regs    = regs;
    cmdSingle    = 1'b0;
    cmdParity    = 1'b0;
    wrFire       = awready & wready;
    modeWriteOk  = 1'b1;
    if (awvalid && wvalid && !awready && !bvalid) begin
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (wrFire) begin
      next_bvalid = 1'b1;
      next_bresp  = pte_pkg::RESP_OKAY;
      case (awaddr)
        pte_pkg::ADDR_CTRL: begin
          next_regs.ctrl = ((regs.ctrl & ~strbMask) | (wdata & strbMask)) & pte_pkg::MASK_CTRL;
          // A sequence trigger request is dropped until a sequence is resident.
          if (next_regs.ctrl[pte_pkg::CTRL_MODE_LSB +: 2] == pte_pkg::TRIG_SEQ && !seqLoaded) begin // RQ7
            modeWriteOk = 1'b0;
          end
          if (!modeWriteOk) begin
            next_regs.ctrl[pte_pkg::CTRL_MODE_LSB +: 2] = regs.ctrl[pte_pkg::CTRL_MODE_LSB +: 2];
          end
        end
        pte_pkg::ADDR_TRIG: next_regs.trig = ((regs.trig & ~strbMask) | (wdata & strbMask)) & pte_pkg::MASK_TRIG;
        pte_pkg::ADDR_ERR:  next_regs.err  = ((regs.err & ~strbMask) | (wdata & strbMask)) & pte_pkg::MASK_ERR;
        pte_pkg::ADDR_CMD: begin
          cmdSingle = wstrb[0] & wdata[pte_pkg::CMD_SINGLE];
          cmdParity = wstrb[0] & wdata[pte_pkg::CMD_PARITY];
        end
        default: next_bresp = pte_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid && !arready && !rvalid) begin
      next_arready = 1'b1;
    end
    if (arready) begin
      next_rvalid = 1'b1;
      next_rresp  = pte_pkg::RESP_OKAY;
      case (araddr)
        pte_pkg::ADDR_CTRL: next_rdata = regs.ctrl;
        pte_pkg::ADDR_TRIG: next_rdata = regs.trig;
        pte_pkg::ADDR_ERR:  next_rdata = regs.err;
        pte_pkg::ADDR_CMD:  next_rdata = 32'h0000_0000;
        pte_pkg::ADDR_STAT: next_rdata = statusWord;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = pte_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= pte_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= pte_pkg::RESP_OKAY;
      regs    <= '{ctrl: 32'h0000_0000, trig: pte_pkg::RST_TRIG, err: 32'h0000_0000};
    end else begin
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      regs    <= next_regs;
    end
  end

  // Trigger path.
  always_comb begin
    halfHi      = ({1'b0, divider} + 9'h001) >> 1;
    divHigh     = {1'b0, divCnt} < halfHi; // RQ3 RQ4
    next_divCnt = (divCnt + 8'h01 >= divider) ? 8'h00 : divCnt + 8'h01; // RQ3 RQ4
    patHigh     = patternStart | (patCnt != 6'h00); // RQ1
    next_patCnt = patternStart ? pte_pkg::PAT_PULSE_LEN - 6'h01 : (patCnt != 6'h00 ? patCnt - 6'h01 : 6'h00); // RQ1
    patTerm     = patHigh & ~seqMode; // RQ5
    seqSpike    = blockStart & blockTrigFlag & seqLoaded; // RQ2
    case (trigMode)
      pte_pkg::TRIG_DIV: rawTrig = divHigh; // RQ5
      pte_pkg::TRIG_PAT: rawTrig = patTerm;
      pte_pkg::TRIG_SEQ: rawTrig = seqSpike;
      default:           rawTrig = 1'b0;
    endcase
    next_trigPipe = {trigPipe[13:0], rawTrig};
    // Data leaves through one register too, so a zero delay keeps both edges together.
    next_trigOut  = (trigDelay == 4'h0) ? rawTrig : trigPipe[trigDelay - 4'h1]; // RQ6
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      divCnt   <= 8'h00;
      patCnt   <= 6'h00;
      trigPipe <= 15'h0000;
      trigOut  <= 1'b0;
    end else begin
      divCnt   <= next_divCnt;
      patCnt   <= next_patCnt;
      trigPipe <= next_trigPipe;
      trigOut  <= next_trigOut;
    end
  end

  // Fixed seeds make two channels fed the same sequence emit identical bits.
  pte_lfsr #(.SEED(pte_pkg::SEED_BIT)) bitRng (.mclk(mclk), .srst(srst), .state(lfsrBit)); // RQ18
  pte_lfsr #(.SEED(pte_pkg::SEED_FEC)) fecRng (.mclk(mclk), .srst(srst), .state(lfsrFec)); // RQ19

  // Error path. The encoder sits outside; its output bit returns on encIn.
  always_comb begin
    ratioMask       = (pte_pkg::ONE16 << regs.err[pte_pkg::ERR_RATIO_LSB +: 4]) - pte_pkg::ONE16;
    next_periodCnt  = (periodCnt >= ratioMask) ? 16'h0000 : periodCnt + pte_pkg::ONE16;
    ratioHit        = regs.ctrl[pte_pkg::CTRL_ERRMODE] ? (periodCnt == 16'h0000)
                                                       : ((lfsrBit & ratioMask) == 16'h0000); // RQ9
    bitFlip         = (regs.ctrl[pte_pkg::CTRL_ERREN] & ratioHit) | singlePend; // RQ8 RQ9 RQ10
    next_singlePend = (cmdSingle & regs.ctrl[pte_pkg::CTRL_SINGLEEN]) | (singlePend & ~singlePend); // RQ10
    next_parityPend = cmdParity; // RQ17
    next_preEncOut  = dataIn ^ parityPend; // RQ17
    curIdx          = frameStart ? 4'h0 : bitCnt;
    curLeft         = frameStart ? pte_pkg::FRAME_SYMS : symLeft;
    curRem          = frameStart ? regs.err[pte_pkg::ERR_NSYM_LSB +: 6] : remaining;
    randPos         = (lfsrFec[6:3] >= pte_pkg::SYM_BITS) ? lfsrFec[6:3] - pte_pkg::POS_WRAP : lfsrFec[6:3]; // RQ16 RQ19
    // Forcing a hit once the symbols left equal the errors owed keeps the count exact.
    symHit          = (curIdx == 4'h0) && (curLeft != 10'h000) && (curRem != 6'h00)
                      && regs.ctrl[pte_pkg::CTRL_FECERREN] && encoderEnable
                      && (({4'h0, curRem} >= curLeft) || (lfsrFec[2:0] == 3'h0)); // RQ16
    symFlip         = (symHit && randPos == 4'h0) || (armed && curIdx == armPos); // RQ16
    next_armed      = symHit ? (randPos != 4'h0) : (armed && curIdx != armPos);
    next_armPos     = symHit ? randPos : armPos;
    next_remaining  = curRem - {5'h00, symHit};
    next_symLeft    = (curIdx == 4'h0 && curLeft != 10'h000) ? curLeft - 10'h001 : curLeft;
    next_bitCnt     = (curIdx == pte_pkg::SYM_BITS - 4'h1) ? 4'h0 : curIdx + 4'h1;
    // Plain data bypasses the encoder; a block switch may show stale encoded bits.
    baseBit         = encoderEnable ? (encIn ^ symFlip) : dataIn; // RQ12 RQ14 RQ15
    next_dataOut    = baseBit ^ bitFlip; // RQ11
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      periodCnt     <= 16'h0000;
      singlePend    <= 1'b0;
      parityPend    <= 1'b0;
      preEncOut     <= 1'b0;
      bitCnt        <= 4'h0;
      symLeft       <= 10'h000;
      remaining     <= 6'h00;
      armed         <= 1'b0;
      armPos        <= 4'h0;
      dataOut       <= 1'b0;
      encoderEnable <= 1'b0;
    end else begin
      periodCnt     <= next_periodCnt;
      singlePend    <= next_singlePend;
      parityPend    <= next_parityPend;
      preEncOut     <= next_preEncOut;
      bitCnt        <= next_bitCnt;
      symLeft       <= next_symLeft;
      remaining     <= next_remaining;
      armed         <= next_armed;
      armPos        <= next_armPos;
      dataOut       <= next_dataOut;
      encoderEnable <= fecPattern; // RQ12
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence sPatHold;
    ##31 patHigh;
  endsequence

  AST_PAT_PULSE: assert property (patternStart |-> sPatHold) else $error("Pattern pulse too short."); // RQ1
  AST_SEQ_SPIKE: assert property (trigMode == pte_pkg::TRIG_SEQ && blockStart && blockTrigFlag && seqLoaded
                                  |-> rawTrig) else $error("Sequence spike missing."); // RQ2
  AST_SEQ_QUIET: assert property (trigMode == pte_pkg::TRIG_SEQ && !(blockStart && blockTrigFlag)
                                  |-> !rawTrig) else $error("Spike on unflagged block."); // RQ2
  AST_DIV_WRAP: assert property (divider >= 8'h02 && divCnt == divider - 8'h01 && $stable(divider)
                                 |=> divCnt == 8'h00 && divHigh) else $error("Divided clock period wrong."); // RQ3
  AST_DIV_FALL: assert property ($fell(divHigh) && $stable(divider) && divider >= 8'h02
                                 |-> {1'b0, divCnt} == halfHi) else $error("Divided clock high time wrong."); // RQ4
  AST_PAT_SUPP: assert property (seqMode |-> !patTerm) else $error("Pattern trigger in sequence mode."); // RQ5
  AST_DELAY_ZERO: assert property (trigDelay == 4'h0 |=> trigOut == $past(rawTrig))
                  else $error("Zero delay not aligned."); // RQ6
  AST_SEQ_LOCK: assert property (wrFire && awaddr == pte_pkg::ADDR_CTRL && !seqLoaded
                                 |=> trigMode == $past(trigMode) || trigMode != pte_pkg::TRIG_SEQ)
                else $error("Sequence trigger taken without sequence."); // RQ7
  AST_SINGLE: assert property (singlePend && !(regs.ctrl[pte_pkg::CTRL_ERREN] && ratioHit)
                               |=> dataOut != $past(baseBit)) else $error("Single error not inserted."); // RQ10
  AST_PARITY: assert property (parityPend |=> preEncOut != $past(dataIn)) else $error("Parity error lost."); // RQ17
  AST_FEC_GATE: assert property (!fecPattern |=> !encoderEnable) else $error("Encoder on without encoded pattern."); // RQ12
endmodule // pte_top
`default_nettype wire

// [bench/pte_encoder_model.sv]
/*
  Behavioural model of the external encoder on the far side of the channel.
  Assumes one bit per mclk cycle and that the bench holds the pattern choice steady.
*/
`timescale 1ns/100ps
`default_nettype none
module pte_encoder_model #(
  parameter int FRAME_BITS = 5440
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Channel side
  input  wire logic encoderEnable,
  input  wire logic preEncOut,
  output var  logic encIn,
  output var  logic frameStart
);
  int          bitPos;
  logic [15:0] scram;
  // Outside frames the line toggles, so a stale bit never passes for encoded data.
  always @(posedge mclk) begin
    if (srst) begin
      encIn <= 1'b0;
    end else if (!encoderEnable) begin
      encIn <= ~encIn;
    end else begin
      encIn <= preEncOut ^ scram[0];
    end
    if (srst || !encoderEnable) begin
      bitPos     <= 0;
      frameStart <= 1'b0;
      scram      <= 16'h5A5A;
    end else begin
      frameStart <= (bitPos == 0);
      bitPos     <= (bitPos == FRAME_BITS - 1) ? 0 : bitPos + 1;
      scram      <= {scram[14:0], scram[15] ^ scram[13] ^ scram[12] ^ scram[10]};
    end
  end
endmodule // pte_encoder_model
`default_nettype wire

// [bench/testbench.sv]
/*
  Self-checking bench of the trigger generator and error inserter.
  Assumes pte_top and pte_encoder_model are compiled first; one bit per 10 ns cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0, srst = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        dataIn = 1'b0, patternStart = 1'b0, seqMode = 1'b0, seqLoaded = 1'b0;
  logic        blockStart = 1'b0, blockTrigFlag = 1'b0, fecPattern = 1'b0, refQ = 1'b0, dQ = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, encoderEnable, preEncOut, encIn, frameStart, dataOut, trigOut;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          num_errors = 0, checks = 0, cyc = 0, flips = 0, pflips = 0, fcnt = 0, fsnap = 0, perFrame = 0;
  int          f0, p0, fd, pd;

  pte_top u_dut (
    .mclk(mclk), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .dataIn(dataIn), .patternStart(patternStart), .seqMode(seqMode), .seqLoaded(seqLoaded),
    .blockStart(blockStart), .blockTrigFlag(blockTrigFlag), .fecPattern(fecPattern),
    .encoderEnable(encoderEnable), .preEncOut(preEncOut), .encIn(encIn), .frameStart(frameStart),
    .dataOut(dataOut), .trigOut(trigOut)
  );
  pte_encoder_model u_enc (
    .mclk(mclk), .srst(srst), .encoderEnable(encoderEnable), .preEncOut(preEncOut), .encIn(encIn),
    .frameStart(frameStart)
  );

  always #5 mclk = ~mclk;
  always @(posedge mclk) dataIn <= 1'($urandom);

  // Counts inverted bits against the clean stream; the reference follows the pattern choice, not the design.
  always @(posedge mclk) begin
    cyc++;
    if (!srst) begin
      flips  = flips + int'(dataOut !== refQ);
      pflips = pflips + int'(preEncOut !== dQ);
    end
    refQ <= fecPattern ? encIn : dataIn;
    dQ   <= dataIn;
    if (frameStart === 1'b1) begin
      perFrame = flips - fsnap;
      fsnap    = flips;
      fcnt++;
    end
    if (cyc > 60000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic expect32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && awready === 1'b1) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (!wd && wready === 1'b1) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    // Bready stays high after the answer, so a back-to-back write never drives it twice in one step.
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask

  // Snapshots are taken on the falling edge so they never race the counting process.
  task automatic mark();
    @(negedge mclk);
    f0 = flips;
    p0 = pflips;
    @(posedge mclk);
  endtask

  task automatic delta(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
    fd = flips - f0;
    pd = pflips - p0;
    @(posedge mclk);
  endtask

  task automatic trig_scan(input int n, output int highs, output int rises);
    logic prev;
    highs = 0;
    rises = 0;
    @(posedge mclk);
    prev = trigOut;
    repeat (n) begin
      @(posedge mclk);
      highs += int'(prev === 1'b1);
      rises += int'(prev === 1'b0 && trigOut === 1'b1);
      prev = trigOut;
    end
  endtask

  task automatic pat_pulse(output int lat, output int width);
    patternStart <= 1'b1;
    @(posedge mclk);
    patternStart <= 1'b0;
    lat   = 0;
    width = 0;
    while (trigOut !== 1'b1 && lat < 40) begin
      @(posedge mclk);
      lat++;
    end
    while (trigOut === 1'b1 && width < 80) begin
      @(posedge mclk);
      width++;
    end
  endtask

  task automatic wait_frame(input int t);
    while (fcnt < t) @(posedge mclk);
    @(posedge mclk);
  endtask

  initial begin
    logic [31:0] rd;
    logic [1:0]  rs;
    int          h, r, lat, w, n, base;
    static int   divs[4] = '{8, 6, 5, 3};
    static int   dlys[3] = '{0, 5, 15};
    void'($urandom(32'h855d_4ca6));
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    axr(pte_pkg::ADDR_CTRL, rd, rs);
    expect32(rd, 32'h0000_0000, "ctrl reset value");
    axr(pte_pkg::ADDR_TRIG, rd, rs);
    expect32(rd, pte_pkg::RST_TRIG, "trig reset value");
    axr(8'h14, rd, rs);
    expect32({rd[29:0], rs}, {30'h0, pte_pkg::RESP_SLVERR}, "unmapped read");
    axw(8'h14, 32'hFFFF_FFFF, rs);
    expect32({30'h0, rs}, {30'h0, pte_pkg::RESP_SLVERR}, "unmapped write");
    wr(pte_pkg::ADDR_TRIG, 32'hFFFF_FFFF);
    axr(pte_pkg::ADDR_TRIG, rd, rs);
    expect32(rd, pte_pkg::MASK_TRIG, "trig reserved bits");
    axr(pte_pkg::ADDR_CMD, rd, rs);
    expect32(rd, 32'h0000_0000, "command reads zero");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      n = (i < 4) ? divs[i] : 2 + $urandom_range(40);
      if (i == 6) seqMode <= 1'b1;
      wr(pte_pkg::ADDR_TRIG, 32'(n));
      repeat (2 * n) @(posedge mclk);
      trig_scan(4 * n, h, r);
      expect32(32'(h), 32'(4 * ((n + 1) / 2)), "divided clock high time");
      expect32(32'(r), 32'h0000_0004, "divided clock periods");
    end
    $display("test divided clock done");
    seqMode <= 1'b0;
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(pte_pkg::ADDR_TRIG, 32'h0000_0008 | 32'(dlys[i] << 8));
      repeat (40) @(posedge mclk);
      pat_pulse(lat, w);
      expect32(32'(lat), 32'(1 + dlys[i]), "trigger latency");
      expect32(32'(w), 32'h0000_0020, "pattern trigger width");
    end
    seqMode <= 1'b1;
    repeat (40) @(posedge mclk);
    pat_pulse(lat, w);
    expect32(32'(lat), 32'h0000_0028, "pattern trigger in sequence mode");
    $display("test pattern trigger done");
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0002);
    axr(pte_pkg::ADDR_CTRL, rd, rs);
    expect32({30'h0, rd[1:0]}, 32'h0000_0001, "sequence mode without sequence");
    seqLoaded <= 1'b1;
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0002);
    axr(pte_pkg::ADDR_CTRL, rd, rs);
    expect32({30'h0, rd[1:0]}, 32'h0000_0002, "sequence mode with sequence");
    for (int f = 1; f >= 0; f--) begin
      blockTrigFlag <= 1'(f);
      blockStart    <= 1'b1;
      @(posedge mclk);
      blockStart <= 1'b0;
      trig_scan(30, h, r);
      expect32(32'(h), 32'(f), "sequence spike");
    end
    seqMode <= 1'b0;
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test sequence trigger done");
    mark();
    delta(199);
    expect32(32'(fd), 32'h0000_0000, "clean stream");
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0010);
    mark();
    wr(pte_pkg::ADDR_CMD, 32'h0000_0001);
    delta(30);
    expect32(32'(fd), 32'h0000_0001, "single error");
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0000);
    mark();
    wr(pte_pkg::ADDR_CMD, 32'h0000_0001);
    delta(30);
    expect32(32'(fd), 32'h0000_0000, "single error disabled");
    mark();
    wr(pte_pkg::ADDR_CMD, 32'h0000_0002);
    delta(30);
    expect32(32'(pd), 32'h0000_0001, "parity error");
    expect32(32'(fd), 32'h0000_0000, "parity error on output");
    for (int k = 2; k <= 4; k += 2) begin
      wr(pte_pkg::ADDR_ERR, 32'(k));
      wr(pte_pkg::ADDR_CTRL, 32'h0000_000C);
      mark();
      delta(255);
      expect32(32'(fd), 32'(256 >> k), "periodic error count");
    end
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0004);
    mark();
    delta(1023);
    expect32(32'(fd >= 32 && fd <= 96), 32'h0000_0001, "random error count");
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test error insertion done");
    fecPattern <= 1'b1;
    repeat (5) @(posedge mclk);
    expect32({31'h0, encoderEnable}, 32'h0000_0001, "encoder on");
    axr(pte_pkg::ADDR_STAT, rd, rs);
    expect32(rd & 32'hFFFF_FFFE, 32'h0000_000C, "status flags");
    wr(pte_pkg::ADDR_ERR, 32'h0000_0006);
    wr(pte_pkg::ADDR_CTRL, 32'h0000_000C);
    base = fcnt;
    wait_frame(base + 2);
    expect32(32'(perFrame), 32'h0000_0055, "bit errors on encoded frame");
    wr(pte_pkg::ADDR_CTRL, 32'h0000_0020);
    wr(pte_pkg::ADDR_ERR, 32'h0000_0030);
    base = fcnt;
    wait_frame(base + 2);
    expect32(32'(perFrame), 32'h0000_0003, "symbol errors per frame");
    wait_frame(base + 3);
    expect32(32'(perFrame), 32'h0000_0003, "symbol errors next frame");
    fecPattern <= 1'b0;
    repeat (5) @(posedge mclk);
    expect32({31'h0, encoderEnable}, 32'h0000_0000, "encoder off");
    $display("test encoded errors done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
